// file: include/ocuvf_pkg.sv
// Package: register map, field positions and timing for the fault handler
package ocuvf_pkg;
    // Printed offsets are not all multiples of four: byte address = index * 4
    localparam logic [7:0] PROT_THRESH_IDX = 8'h5E;
    localparam logic [7:0] BLANK_CFG_IDX = 8'h60;
    localparam logic [7:0] RESP_CFG_IDX = 8'h70;
    localparam logic [7:0] STATUS_IDX = 8'h71;
    localparam logic [7:0] CONTROL_IDX = 8'h72;
    localparam logic [15:0] PROT_THRESH_RST = 16'h0000;
    localparam logic [15:0] BLANK_CFG_RST = 16'h0000;
    localparam logic [15:0] RESP_CFG_RST = 16'h0000;
    // Field positions
    localparam int VALLEY_SEL_LSB = 0;
    localparam int UV_THRESH_LSB = 8;
    localparam int UV_BLANK_LSB = 10;
    localparam int OC_RESP_LSB = 0;
    localparam int UV_RESP_LSB = 2;
    localparam int RETRY_MS_LSB = 4;
    localparam int VALLEY_SEL_SRC_BIT = 7;
    // Counts
    localparam logic [3:0] VALLEY_TRIP_COUNT = 4'hA;
    localparam logic [1:0] CLEAN_CYCLE_COUNT = 2'h3;
    localparam logic [2:0] OC_RETRY_LIMIT = 3'h6;
    localparam int CLK_MHZ = 100;
    localparam int RETRY_STEP_US = 1000;
    localparam int MS_CYCLES = RETRY_STEP_US * CLK_MHZ;
    localparam logic [15:0] UV_STEP_MV = 16'h0032;
    localparam logic [15:0] RESTART_LEVEL_MV = 16'h00FA;

    typedef enum logic [1:0] {
        OCUVF_OC_SHUTDOWN = 2'b00,
        OCUVF_OC_RETRY6 = 2'b01,
        OCUVF_OC_RETRY_ALWAYS = 2'b10
    } ocuvf_oc_resp_type;

    typedef enum logic [1:0] {
        OCUVF_UV_IGNORE = 2'b00,
        OCUVF_UV_SHUTDOWN = 2'b01,
        OCUVF_UV_RETRY = 2'b10
    } ocuvf_uv_resp_type;

    typedef enum logic [1:0] {
        OCUVF_RUN = 2'b00,
        OCUVF_WAIT = 2'b01,
        OCUVF_LATCHED = 2'b10
    } ocuvf_state_type;

    // Per-cycle inputs from the power stage
    typedef struct packed {
        logic pwm_rise;
        logic valley;
        logic valley_oc;
        logic avg_oc;
        logic uv;
        logic vboot_ramp;
        logic vout_up;
        logic vout_down;
    } ocuvf_stage_type;

    // Avalon-MM request
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } ocuvf_avm_type;
endpackage

// file: verilog/ocuvf_fault_handler.sv
// Overcurrent and undervoltage fault handler with Avalon-MM registers
// What this block does
// - Valley trip holds low side, skips next pulse
// - Trip at PWM rise blocks that pulse
// - Keep skipping while current stays over limit
// - Ten valley events trigger average-overcurrent response
// - Three clean cycles reset the event counter
// - Count events at inductor current valley
// - Valley protection active in all run modes
// - Valley protection armed only while enabled
// - Three-bit field selects valley threshold
// - Limit pin latched at each enable rising edge
// - Average fault: shutdown, six retries, or endless
// - Average compare separate from valley compare
// - Fewer than ten valley events keep power good
// - Undervoltage threshold 50-400 mV, 50 mV steps
// - Undervoltage response: ignore, shutdown, retry
// - Undervoltage flags; shutdown holds tri-state until enable cycle
// - Shutdown tri-states both switches
// - Retry timer 1-8 ms, output tri-stated
// - Restart only if output below 250 mV
// - Otherwise restart timer, stay tri-stated
// - Two-bit undervoltage blanking select
// - Trip comes from fast comparator input
`timescale 1ns/1ns
`default_nettype none
module ocuvf_fault_handler
#(
    parameter int MS_CYCLES_P = ocuvf_pkg::MS_CYCLES
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Power stage
    input wire logic i_enable,
    input wire logic i_diode_emulation_mode,
    input wire logic [2:0] i_limit_resistor_pin,
    input wire ocuvf_pkg::ocuvf_stage_type i_stage,
    input wire logic [15:0] i_vout_mv,
    output logic o_hs_block,
    output logic o_ls_hold,
    output logic o_tristate,
    output logic o_startup,
    output logic o_power_good_output,
    output logic [2:0] o_valley_limit_sel,
    output logic [2:0] o_uv_thresh_sel,
    output logic [15:0] o_uv_thresh_mv,
    // Avalon-MM slave
    input wire ocuvf_pkg::ocuvf_avm_type i_avm,
    output logic o_avm_waitrequest,
    output logic [31:0] o_avm_readdata,
    output logic o_avm_readdatavalid
);
    logic [15:0] prot_thresh_r;
    logic [15:0] blank_cfg_r;
    logic [15:0] resp_cfg_r;
    logic [2:0] limit_latch_r;
    logic en_d_r;
    logic armed_r;
    logic skip_r;
    logic [3:0] event_cnt_r;
    logic [1:0] clean_cnt_r;
    logic oc_fault_r;
    logic uv_fault_r;
    logic oc_latched_r;
    logic [2:0] oc_retry_r;
    ocuvf_pkg::ocuvf_state_type state_r;
    logic [31:0] timer_r;
    logic [3:0] ms_left_r;
    logic uv_is_retry_r;
    logic start_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic trip_now;
    logic oc_event;
    logic uv_blanked;
    logic uv_event;
    logic clear_faults;
    logic en_rise;
    ocuvf_pkg::ocuvf_oc_resp_type oc_resp;
    ocuvf_pkg::ocuvf_uv_resp_type uv_resp;

    function automatic logic [15:0] uv_mv(input logic [2:0] sel);
        uv_mv = 16'(({13'h0000, sel} + 16'h0001) * ocuvf_pkg::UV_STEP_MV);
    endfunction

    assign oc_resp = ocuvf_pkg::ocuvf_oc_resp_type'(resp_cfg_r[ocuvf_pkg::OC_RESP_LSB +: 2]);
    assign uv_resp = ocuvf_pkg::ocuvf_uv_resp_type'(resp_cfg_r[ocuvf_pkg::UV_RESP_LSB +: 2]);
    assign en_rise = i_enable && !en_d_r;
    // Comparator result used directly, no telemetry path
    assign trip_now = armed_r && i_stage.valley_oc;
    // Enable edge and valley limit latch
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            en_d_r <= 1'b0;
            armed_r <= 1'b0;
            limit_latch_r <= 3'h0;
        end
        else
        begin
            en_d_r <= i_enable;
            armed_r <= i_enable;
            if (en_rise)
            begin
                limit_latch_r <= i_limit_resistor_pin;
            end
        end
    end

    // Register field overrides the pin when its source bit is set
    assign o_valley_limit_sel = prot_thresh_r[ocuvf_pkg::VALLEY_SEL_SRC_BIT] ?
        prot_thresh_r[ocuvf_pkg::VALLEY_SEL_LSB +: 3] : limit_latch_r;
    assign o_uv_thresh_sel = prot_thresh_r[ocuvf_pkg::UV_THRESH_LSB +: 3];

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_uv_thresh_mv <= ocuvf_pkg::UV_STEP_MV;
        else
            o_uv_thresh_mv <= uv_mv(o_uv_thresh_sel);
    end

    // Pulse skipping; same in forced continuous and diode emulation
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            skip_r <= 1'b0;
        else if (trip_now)
            skip_r <= 1'b1;
        else if (i_stage.pwm_rise)
            skip_r <= 1'b0;
    end

    assign o_ls_hold = trip_now || (skip_r && !o_tristate);
    assign o_hs_block = o_tristate || trip_now || skip_r;

    // Valley event counting
    assign oc_event = i_stage.valley && trip_now;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            event_cnt_r <= 4'h0;
            clean_cnt_r <= 2'h0;
        end
        else if (!armed_r)
        begin
            event_cnt_r <= 4'h0;
            clean_cnt_r <= 2'h0;
        end
        else if (i_stage.valley)
        begin
            if (oc_event)
            begin
                clean_cnt_r <= 2'h0;
                if (event_cnt_r == ocuvf_pkg::VALLEY_TRIP_COUNT - 4'h1)
                    event_cnt_r <= 4'h0;
                else
                    event_cnt_r <= event_cnt_r + 4'h1;
            end
            else if (clean_cnt_r == ocuvf_pkg::CLEAN_CYCLE_COUNT - 2'h1)
            begin
                clean_cnt_r <= 2'h0;
                event_cnt_r <= 4'h0;
            end
            else
                clean_cnt_r <= clean_cnt_r + 2'h1;
        end
    end

    // Average limit fault from its own compare or from ten valley events
    logic oc_trigger;
    assign oc_trigger = (i_stage.avg_oc && armed_r) || (oc_event &&
        event_cnt_r == ocuvf_pkg::VALLEY_TRIP_COUNT - 4'h1);

    // Undervoltage blanking
    always_comb
    begin
        unique case (blank_cfg_r[ocuvf_pkg::UV_BLANK_LSB +: 2])
            2'b00: uv_blanked = 1'b0;
            2'b01: uv_blanked = i_stage.vboot_ramp;
            2'b10: uv_blanked = i_stage.vboot_ramp || i_stage.vout_up;
            2'b11: uv_blanked = i_stage.vboot_ramp || i_stage.vout_up || i_stage.vout_down;
        endcase
    end
    assign uv_event = i_stage.uv && !uv_blanked && armed_r &&
        uv_resp != ocuvf_pkg::OCUVF_UV_IGNORE && state_r == ocuvf_pkg::OCUVF_RUN;

    assign clear_faults = ack_r && i_avm.write && i_avm.address == ocuvf_pkg::CONTROL_IDX &&
        i_avm.writedata[0];

    // Fault flags; a new event wins over a clear
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            oc_fault_r <= 1'b0;
            uv_fault_r <= 1'b0;
        end
        else
        begin
            if (oc_trigger)
                oc_fault_r <= 1'b1;
            else if (clear_faults)
                oc_fault_r <= 1'b0;
            if (uv_event)
                uv_fault_r <= 1'b1;
            else if (clear_faults)
                uv_fault_r <= 1'b0;
        end
    end

    // Power good drops on undervoltage, in any fault state, or while disabled
    assign o_power_good_output = armed_r && !uv_fault_r && state_r == ocuvf_pkg::OCUVF_RUN;

    // Fault response sequencer
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ocuvf_pkg::OCUVF_RUN;
            timer_r <= 32'h0;
            ms_left_r <= 4'h0;
            oc_retry_r <= 3'h0;
            oc_latched_r <= 1'b0;
            uv_is_retry_r <= 1'b0;
            start_r <= 1'b0;
        end
        else if (en_rise)
        begin
            // Enable cycle is the only way out of a latched state
            state_r <= ocuvf_pkg::OCUVF_RUN;
            oc_retry_r <= 3'h0;
            oc_latched_r <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            start_r <= 1'b0;
            unique case (state_r)
                ocuvf_pkg::OCUVF_RUN:
                begin
                    if (uv_event)
                    begin
                        if (uv_resp == ocuvf_pkg::OCUVF_UV_RETRY)
                        begin
                            state_r <= ocuvf_pkg::OCUVF_WAIT;
                            uv_is_retry_r <= 1'b1;
                            timer_r <= 32'(MS_CYCLES_P - 1);
                            ms_left_r <= {1'b0, resp_cfg_r[ocuvf_pkg::RETRY_MS_LSB +: 3]};
                        end
                        else
                            state_r <= ocuvf_pkg::OCUVF_LATCHED;
                    end
                    else if (oc_trigger)
                    begin
                        if (oc_resp == ocuvf_pkg::OCUVF_OC_SHUTDOWN ||
                            (oc_resp == ocuvf_pkg::OCUVF_OC_RETRY6 &&
                            oc_retry_r == ocuvf_pkg::OC_RETRY_LIMIT))
                        begin
                            state_r <= ocuvf_pkg::OCUVF_LATCHED;
                            oc_latched_r <= 1'b1;
                        end
                        else
                        begin
                            state_r <= ocuvf_pkg::OCUVF_WAIT;
                            uv_is_retry_r <= 1'b0;
                            timer_r <= 32'(MS_CYCLES_P - 1);
                            ms_left_r <= {1'b0, resp_cfg_r[ocuvf_pkg::RETRY_MS_LSB +: 3]};
                            if (oc_resp == ocuvf_pkg::OCUVF_OC_RETRY6)
                                oc_retry_r <= oc_retry_r + 3'h1;
                        end
                    end
                end
                ocuvf_pkg::OCUVF_WAIT:
                begin
                    if (timer_r != 32'h0)
                        timer_r <= timer_r - 32'h1;
                    else if (ms_left_r != 4'h0)
                    begin
                        ms_left_r <= ms_left_r - 4'h1;
                        timer_r <= 32'(MS_CYCLES_P - 1);
                    end
                    else if (i_vout_mv < ocuvf_pkg::RESTART_LEVEL_MV)
                    begin
                        state_r <= ocuvf_pkg::OCUVF_RUN;
                        start_r <= 1'b1;
                    end
                    else
                    begin
                        timer_r <= 32'(MS_CYCLES_P - 1);
                        ms_left_r <= {1'b0, resp_cfg_r[ocuvf_pkg::RETRY_MS_LSB +: 3]};
                    end
                end
                ocuvf_pkg::OCUVF_LATCHED: state_r <= ocuvf_pkg::OCUVF_LATCHED;
                default: state_r <= ocuvf_pkg::OCUVF_LATCHED;
            endcase
        end
    end

    assign o_tristate = state_r != ocuvf_pkg::OCUVF_RUN || !armed_r;
    assign o_startup = start_r;

    // Avalon-MM slave: one wait cycle, then answer
    assign o_avm_waitrequest = (i_avm.read || i_avm.write) && !ack_r;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ack_r <= 1'b0;
            prot_thresh_r <= ocuvf_pkg::PROT_THRESH_RST;
            blank_cfg_r <= ocuvf_pkg::BLANK_CFG_RST;
            resp_cfg_r <= ocuvf_pkg::RESP_CFG_RST;
        end
        else
        begin
            ack_r <= (i_avm.read || i_avm.write) && !ack_r;
            if (ack_r && i_avm.write)
            begin
                unique case (i_avm.address)
                    ocuvf_pkg::PROT_THRESH_IDX: prot_thresh_r <= i_avm.writedata[15:0];
                    ocuvf_pkg::BLANK_CFG_IDX: blank_cfg_r <= i_avm.writedata[15:0];
                    ocuvf_pkg::RESP_CFG_IDX: resp_cfg_r <= i_avm.writedata[15:0];
                    default: ;
                endcase
            end
        end
    end

    always_comb
    begin
        unique case (i_avm.address)
            ocuvf_pkg::PROT_THRESH_IDX: rdata_r = {16'h0000, prot_thresh_r};
            ocuvf_pkg::BLANK_CFG_IDX: rdata_r = {16'h0000, blank_cfg_r};
            ocuvf_pkg::RESP_CFG_IDX: rdata_r = {16'h0000, resp_cfg_r};
            ocuvf_pkg::STATUS_IDX: rdata_r = {21'h000000, oc_retry_r, limit_latch_r,
                oc_latched_r, state_r, oc_fault_r, uv_fault_r};
            default: rdata_r = 32'h0000_0000;
        endcase
    end

    assign o_avm_readdata = rdata_r;
    assign rvalid_r = ack_r && i_avm.read;
    assign o_avm_readdatavalid = rvalid_r;

    default clocking cb_sys @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_skip;
        trip_now && !i_stage.pwm_rise |=> o_hs_block;
    endproperty
    a_skip: assert property (p_skip) else $error("pulse not skipped");
    property p_rise;
        trip_now && i_stage.pwm_rise |-> o_hs_block;
    endproperty
    a_rise: assert property (p_rise) else $error("rise not blocked");
    property p_unarmed;
        !armed_r |-> !o_ls_hold && o_tristate;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("trip while disabled");
    property p_pg_uv;
        uv_event |=> !o_power_good_output;
    endproperty
    a_pg_uv: assert property (p_pg_uv) else $error("power good kept on uv");
    property p_uv_flag;
        uv_event |=> uv_fault_r && o_tristate;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("uv flag missing");
    property p_restart;
        o_startup |-> $past(i_vout_mv) < ocuvf_pkg::RESTART_LEVEL_MV;
    endproperty
    a_restart: assert property (p_restart) else $error("restart above level");
    property p_tenth;
        oc_event && event_cnt_r == 4'h9 |-> oc_trigger;
    endproperty
    a_tenth: assert property (p_tenth) else $error("tenth lost");
    property p_clean;
        i_stage.valley && armed_r && !oc_event && clean_cnt_r == 2'h2 |=> event_cnt_r == 4'h0;
    endproperty
    a_clean: assert property (p_clean) else $error("counter not reset");
    property p_dem;
        armed_r && i_stage.valley_oc && i_diode_emulation_mode |-> o_ls_hold && o_hs_block;
    endproperty
    a_dem: assert property (p_dem) else $error("trip lost in diode mode");
endmodule
`default_nettype wire

// file: tb/ocuvf_stage_model.sv
// Power stage comparator model: switching-cycle pulses and fault levels
`timescale 1ns/1ns
`default_nettype none
module ocuvf_stage_model
#(
    parameter int PERIOD = 8
)
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Levels from the bench
    input wire logic i_oc,
    input wire logic i_avg_oc,
    input wire logic i_uv,
    input wire logic [2:0] i_ramp,
    // To the fault handler
    output var ocuvf_pkg::ocuvf_stage_type o_stage
);
    logic [7:0] phase_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_r <= 8'h00;
        end
        else
        begin
            phase_r <= (phase_r == 8'(PERIOD - 1)) ? 8'h00 : phase_r + 8'h01;
        end
    end

    // Valley late in the cycle, after the low side has conducted
    always_comb
    begin
        o_stage.pwm_rise = (phase_r == 8'h00);
        o_stage.valley = (phase_r == 8'(PERIOD - 3));
        o_stage.valley_oc = i_oc;
        o_stage.avg_oc = i_avg_oc;
        o_stage.uv = i_uv;
        {o_stage.vboot_ramp, o_stage.vout_up, o_stage.vout_down} = i_ramp;
    end
endmodule
`default_nettype wire

// file: tb/ocuvf_fault_handler_bench.sv
// Self-checking bench for the fault handler
`timescale 1ns/1ns
`default_nettype none
module ocuvf_fault_handler_bench;
    logic clk, rst_n, en, diode_emulation_mode, oc, avg, uv;
    logic [2:0] lim, ramp, vsel, usel;
    logic [15:0] vout, umv;
    ocuvf_pkg::ocuvf_stage_type stage;
    ocuvf_pkg::ocuvf_avm_type avm;
    logic hs, ls, tri_st, start, pg, wreq, rvalid;
    logic [31:0] rdata, st;
    int fails, num_checks;

    ocuvf_stage_model model (.i_sys_clk(clk), .i_rst_n(rst_n), .i_oc(oc), .i_avg_oc(avg),
        .i_uv(uv), .i_ramp(ramp), .o_stage(stage));
    ocuvf_fault_handler #(.MS_CYCLES_P(10)) dut (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_enable(en), .i_diode_emulation_mode(diode_emulation_mode), .i_limit_resistor_pin(lim),
        .i_stage(stage), .i_vout_mv(vout), .o_hs_block(hs), .o_ls_hold(ls),
        .o_tristate(tri_st), .o_startup(start), .o_power_good_output(pg),
        .o_valley_limit_sel(vsel), .o_uv_thresh_sel(usel), .o_uv_thresh_mv(umv),
        .i_avm(avm), .o_avm_waitrequest(wreq), .o_avm_readdata(rdata),
        .o_avm_readdatavalid(rvalid));

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_word({31'h0, got}, {31'h0, exp}, msg);
    endtask

    // Master holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        avm <= '{address: idx, read: ~wr, write: wr, writedata: wd};
        @(posedge clk);
        while (wreq !== 1'b0 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 100)
            chk_bit(1'b1, 1'b0, "bus hang");
        // Data and valid are taken at the edge that sees waitrequest low
        rd = rdata;
        chk_bit(rvalid, ~wr, "read data valid");
        avm <= '0;
    endtask

    task automatic wr_reg(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rd_reg(input logic [7:0] idx, output logic [31:0] rd);
        bus(1'b0, idx, 32'h0, rd);
    endtask

    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic valleys(input int n);
        repeat (n)
        begin
            do @(negedge clk); while (stage.valley !== 1'b1);
        end
    endtask

    task automatic set_lvl(input logic o, input logic a, input logic u, input logic [2:0] r);
        @(posedge clk);
        oc <= o;
        avg <= a;
        uv <= u;
        ramp <= r;
    endtask

    // Enable cycle clears latched faults and reloads the limit pin
    task automatic en_cycle();
        @(posedge clk);
        en <= 1'b0;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        ticks(4);
    endtask

    task automatic wait_start(input int n, output logic seen);
        seen = 1'b0;
        repeat (n)
        begin
            @(negedge clk);
            if (start === 1'b1)
                seen = 1'b1;
        end
    endtask

    task automatic t_regs();
        for (int i = 0; i < 3; i++)
        begin
            rd_reg(i == 0 ? ocuvf_pkg::PROT_THRESH_IDX : i == 1 ? ocuvf_pkg::BLANK_CFG_IDX
                : ocuvf_pkg::RESP_CFG_IDX, st);
            chk_word(st, 32'h0, "reset value");
        end
        for (int s = 0; s < 8; s++)
        begin
            wr_reg(ocuvf_pkg::PROT_THRESH_IDX, 32'(s) << 8);
            ticks(2);
            chk_word(32'(umv), 32'((s + 1) * 50), "uv threshold mv");
            chk_word(32'(usel), 32'(s), "uv threshold sel");
        end
        wr_reg(ocuvf_pkg::BLANK_CFG_IDX, 32'h0000_0C00);
        rd_reg(ocuvf_pkg::BLANK_CFG_IDX, st);
        chk_word(st, 32'h0000_0C00, "blank readback");
        wr_reg(8'h10, 32'h0000_FFFF);
        rd_reg(8'h10, st);
        chk_word(st, 32'h0, "unmapped read");
        rd_reg(ocuvf_pkg::STATUS_IDX, st);
        wr_reg(ocuvf_pkg::STATUS_IDX, 32'h0000_FFFF);
        begin
            logic [31:0] s2;
            rd_reg(ocuvf_pkg::STATUS_IDX, s2);
            chk_word(s2, st, "status read only");
        end
        lim <= 3'h5;
        en_cycle();
        @(posedge clk);
        lim <= 3'h2;
        ticks(3);
        chk_word(32'(vsel), 32'h5, "limit latched at enable");
        wr_reg(ocuvf_pkg::PROT_THRESH_IDX, 32'h0000_0083);
        ticks(2);
        chk_word(32'(vsel), 32'h3, "limit from register");
        wr_reg(ocuvf_pkg::PROT_THRESH_IDX, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_valley();
        logic pg0;
        for (int d = 0; d < 2; d++)
        begin
            @(posedge clk);
            diode_emulation_mode <= d[0];
            ticks(2);
            pg0 = pg;
            set_lvl(1'b1, 1'b0, 1'b0, 3'h0);
            ticks(2);
            chk_bit(ls, 1'b1, "low side held");
            do @(negedge clk); while (stage.pwm_rise !== 1'b1);
            chk_bit(hs, 1'b1, "pulse at rise blocked");
            valleys(3);
            chk_bit(hs, 1'b1, "pulse kept blocked");
            chk_bit(pg, pg0, "power good kept");
            set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
            valleys(3);
            chk_bit(hs, 1'b0, "high side released");
        end
        @(posedge clk);
        en <= 1'b0;
        set_lvl(1'b1, 1'b0, 1'b0, 3'h0);
        ticks(3);
        chk_bit(ls, 1'b0, "no trip while disabled");
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        en <= 1'b1;
        ticks(4);
        $display("test valley done");
    endtask

    task automatic t_count();
        set_lvl(1'b1, 1'b0, 1'b0, 3'h0);
        valleys(9);
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        valleys(3);
        set_lvl(1'b1, 1'b0, 1'b0, 3'h0);
        valleys(9);
        ticks(2);
        chk_bit(tri_st, 1'b0, "count cleared by clean cycles");
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        valleys(2);
        set_lvl(1'b1, 1'b0, 1'b0, 3'h0);
        valleys(1);
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        ticks(3);
        chk_bit(tri_st, 1'b1, "tenth event shuts down");
        rd_reg(ocuvf_pkg::STATUS_IDX, st);
        chk_bit(st[1], 1'b1, "current fault flag");
        en_cycle();
        chk_bit(tri_st, 1'b0, "enable cycle restarts");
        $display("test count done");
    endtask

    task automatic t_avg_retry();
        logic seen;
        for (int m = 1; m < 3; m++)
        begin
            wr_reg(ocuvf_pkg::RESP_CFG_IDX, 32'(m));
            for (int k = 0; k < 7; k++)
            begin
                set_lvl(1'b0, 1'b1, 1'b0, 3'h0);
                ticks(3);
                chk_bit(tri_st, 1'b1, "average fault tri-states");
                set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
                wait_start(40, seen);
                chk_bit(seen, (m == 2) || (k < 6), "retry restart");
            end
            en_cycle();
        end
        $display("test average retry done");
    endtask

    task automatic t_uv();
        logic exp, seen;
        wr_reg(ocuvf_pkg::RESP_CFG_IDX, 32'h0000_0004);
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 3; k++)
            begin
                wr_reg(ocuvf_pkg::BLANK_CFG_IDX, 32'(s) << 10);
                exp = !((k == 0 && s >= 1) || (k == 1 && s >= 2) || (k == 2 && s == 3));
                set_lvl(1'b0, 1'b0, 1'b1, 3'h4 >> k);
                ticks(3);
                chk_bit(tri_st, exp, "uv blanking");
                set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
                if (exp)
                    en_cycle();
            end
        wr_reg(ocuvf_pkg::CONTROL_IDX, 32'h1);
        wr_reg(ocuvf_pkg::BLANK_CFG_IDX, 32'h0);
        chk_bit(pg, 1'b1, "power good before uv");
        set_lvl(1'b0, 1'b0, 1'b1, 3'h0);
        ticks(3);
        chk_bit(pg, 1'b0, "power good falls on uv");
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        rd_reg(ocuvf_pkg::STATUS_IDX, st);
        chk_bit(st[0], 1'b1, "uv flag set");
        wr_reg(ocuvf_pkg::CONTROL_IDX, 32'h1);
        rd_reg(ocuvf_pkg::STATUS_IDX, st);
        chk_bit(st[0], 1'b0, "uv flag cleared");
        chk_bit(tri_st, 1'b1, "clear does not restart");
        en_cycle();
        wr_reg(ocuvf_pkg::RESP_CFG_IDX, 32'h0);
        set_lvl(1'b0, 1'b0, 1'b1, 3'h0);
        ticks(3);
        chk_bit(tri_st, 1'b0, "uv ignored");
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        wr_reg(ocuvf_pkg::RESP_CFG_IDX, 32'h0000_0008);
        @(posedge clk);
        vout <= 16'd250;
        set_lvl(1'b0, 1'b0, 1'b1, 3'h0);
        set_lvl(1'b0, 1'b0, 1'b0, 3'h0);
        wait_start(40, seen);
        chk_bit(seen, 1'b0, "no restart at 250 mV");
        chk_bit(tri_st, 1'b1, "held tri-stated");
        @(posedge clk);
        vout <= 16'd249;
        wait_start(30, seen);
        chk_bit(seen, 1'b1, "restart below 250 mV");
        $display("test undervoltage done");
    endtask

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        #200000;
        fails++;
        conclude();
    end

    initial
    begin
        rst_n = 1'b0;
        {en, diode_emulation_mode, oc, avg, uv} = '0;
        lim = 3'h0;
        ramp = 3'h0;
        vout = 16'd100;
        avm = '0;
        fails = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_valley();
        t_count();
        t_avg_retry();
        t_uv();
        conclude();
    end
endmodule
`default_nettype wire
